// ### core/tsl_defs.svh
/*
 constants for the thermal shutdown limit register set: offsets, field positions,
 reset values and fixed margins. assumes 8-bit registers on an 8-bit address.
*/
`ifndef TSL_DEFS_SVH
`define TSL_DEFS_SVH

`define TSL_OFS_EXT_CRIT_LIMIT 8'h19
`define TSL_OFS_EXT_FAULT_STATUS 8'h1B
`define TSL_OFS_SW_SHDN_CONFIG 8'h1D
`define TSL_OFS_HW_SHDN_LIMIT 8'h1E
`define TSL_OFS_INT_CRIT_LIMIT 8'h20
`define TSL_OFS_CRIT_HYST 8'h21

`define TSL_BIT_EXT_FAULT 1
`define TSL_BIT_EXT_LINK 1
`define TSL_BIT_INT_LINK 0

`define TSL_RST_EXT_CRIT_LIMIT 8'h55
`define TSL_RST_INT_CRIT_LIMIT 8'h55
`define TSL_RST_CRIT_HYST 8'h0A
`define TSL_RST_LINK 2'h0
`define TSL_RST_HW_STEP 6'h00

`define TSL_HW_LIMIT_BASE 8'h4D
`define TSL_HW_STEP_MAX 6'h23
`define TSL_HW_RELEASE_MARGIN 8'h0A
`define TSL_EXT_RANGE_OFFSET 8'h40
`define TSL_SIGN_FLIP 8'h80

`define TSL_CONSEC_1 3'h0
`define TSL_CONSEC_2 3'h1
`define TSL_CONSEC_3 3'h3
`define TSL_CONSEC_4 3'h7
`define TSL_COUNT_1 3'h1
`define TSL_COUNT_2 3'h2
`define TSL_COUNT_3 3'h3
`define TSL_COUNT_4 3'h4

`endif

// ### core/tsl_pkg.sv
/*
 types shared by the thermal shutdown limit block.
 assumes tsl_defs.svh is available for the constant values.
*/
package tsl_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } tsl_reg_req_t;

   typedef struct packed {
      logic [7:0] ext_limit;
      logic [7:0] int_limit;
      logic [7:0] hyst;
      logic [1:0] link;
   } tsl_cfg_t;

   typedef enum logic [2:0] {
      TSL_ARMED = 3'h1,
      TSL_COUNTING = 3'h2,
      TSL_TRIPPED = 3'h4
   } tsl_chan_state_t;

endpackage

// ### core/tsl_crit_chan.sv
/*
 one critical comparison channel: consecutive counter, trip and release.
 assumes all values arrive in the monotonic unsigned compare domain.
*/
`timescale 1ns/1ps
`include "tsl_defs.svh"

module tsl_crit_chan
   import tsl_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic conv_in,
   input wire logic [W-1:0] temp_in,
   input wire logic [W-1:0] limit_in,
   input wire logic [W-1:0] release_in,
   input wire logic [2:0] need_in,
   output logic over_out,
   output logic trip_out
);

   tsl_chan_state_t state_r;
   logic [2:0] cnt_r;
   logic [2:0] cnt_inc;
   logic above;
   logic below_release;

   assign above = temp_in > limit_in;
   assign below_release = temp_in < release_in;
   assign cnt_inc = cnt_r + 3'h1;
   assign trip_out = (state_r == TSL_TRIPPED);

   // latest conversion above limit
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         over_out <= 1'b0;
      end else if (conv_in) begin
         over_out <= above;
      end
   end

   // count, trip and hold until release
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= TSL_ARMED;
         cnt_r <= 3'h0;
      end else if (conv_in) begin
         case (state_r)
            TSL_ARMED, TSL_COUNTING: begin
               if (above && cnt_inc >= need_in) begin
                  state_r <= TSL_TRIPPED;
                  cnt_r <= cnt_inc;
               end else if (above) begin
                  state_r <= TSL_COUNTING;
                  cnt_r <= cnt_inc;
               end else begin
                  state_r <= TSL_ARMED;
                  cnt_r <= 3'h0;
               end
            end
            TSL_TRIPPED: begin
               if (below_release) begin
                  state_r <= TSL_ARMED;
                  cnt_r <= 3'h0;
               end
            end
            default: begin
               state_r <= TSL_ARMED;
               cnt_r <= 3'h0;
            end
         endcase
      end
   end

endmodule

// ### core/tsl_top.sv
/*
 thermal shutdown limit registers and shutdown pin control.
 assumes one conversion pulse per measurement with temperatures in the
 format the range input selects, and a register port driven by the bus engine.
*/
// Operation
// - external critical limit, 8-bit read-write at 0x19, weights 128 to 1.
// - internal critical limit, 8-bit read-write at 0x20, same weights.
// - shared critical hysteresis, 8-bit read-write at 0x21.
// - a read of fault status at 0x1B clears it unless a new fault arrives in the same cycle.
// - fault status bit 1 set on external diode fault; others read zero.
// - fault status names external diode as summary fault source.
// - external linked and above limit: set status, assert shutdown.
// - external unlinked and above limit: set status only.
// - internal linked and above limit: set status, assert shutdown.
// - internal unlinked and above limit: set status only.
// - linked shutdown holds until temperature below limit minus hysteresis.
// - software and hardware comparisons both drive the shutdown pin.
// - read-only hardware limit at 0x1E fixed by sensed pull-ups.
// - hardware limit shown in degrees in currently selected range format.
// - external above hardware limit asserts shutdown until 10 degrees below.
// - shutdown pin is active low, driven low when asserted.
// - shutdown needs 1 to 4 consecutive conversions per code, default 4.
// - alert masks never affect the shutdown pin.
`timescale 1ns/1ps
`include "tsl_defs.svh"

module tsl_top
   import tsl_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_WDATA_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_RVALID_OUT,
   input wire logic CONV_DONE_IN,
   input wire logic [7:0] EXT_TEMP_IN,
   input wire logic [7:0] INT_TEMP_IN,
   input wire logic EXT_DIODE_FAULT_IN,
   input wire logic RANGE_EXT_IN,
   input wire logic [2:0] CONSEC_CRIT_CODE_IN,
   input wire logic [5:0] HW_LIMIT_STRAP_IN,
   output logic SYSTEM_SHUTDOWN_N_OUT,
   output logic SYSTEM_SHUTDOWN_OE_OUT,
   output logic EXT_CRITICAL_STATUS_OUT,
   output logic INT_CRITICAL_STATUS_OUT,
   output logic EXT_DIODE_FAULT_FLAG_OUT
);

   logic rst_meta_r;
   logic rst_sync_r;
   tsl_reg_req_t req;
   tsl_cfg_t cfg_r;
   logic ext_diode_fault_flag_r;
   logic strap_done_r;
   logic [5:0] hw_step_r;
   logic [5:0] hw_step_sat;
   logic [7:0] hw_limit_value;
   logic [7:0] read_mux;
   logic [2:0] consecutive_critical_count;
   logic [7:0] ext_temp_u;
   logic [7:0] int_temp_u;
   logic [7:0] ext_limit_u;
   logic [7:0] int_limit_u;
   logic [7:0] hw_limit_u;
   logic [7:0] ext_release_u;
   logic [7:0] int_release_u;
   logic [7:0] hw_release_u;
   logic ext_over;
   logic int_over;
   logic hw_over;
   logic ext_trip;
   logic int_trip;
   logic hw_trip;
   logic shutdown_nxt;
   logic fault_rd;

   // map a reading in the active format to a monotonic unsigned value
   function automatic logic [7:0] to_cmp(input logic [7:0] v, input logic ext_range);
      logic [7:0] r;
      r = ext_range ? v : (v ^ `TSL_SIGN_FLIP);
      return r;
   endfunction

   // limit minus margin, floored at the bottom of the range
   function automatic logic [7:0] sub_floor(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      r = (a > b) ? (a - b) : 8'h00;
      return r;
   endfunction

   // reset release through two flops
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   assign req.addr = REG_ADDR_IN;
   assign req.wr = REG_WR_IN;
   assign req.rd = REG_RD_IN;
   assign req.wdata = REG_WDATA_IN;

   // external critical limit
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         cfg_r.ext_limit <= `TSL_RST_EXT_CRIT_LIMIT;
      end else if (req.wr && req.addr == `TSL_OFS_EXT_CRIT_LIMIT) begin
         cfg_r.ext_limit <= req.wdata;
      end
   end

   // internal critical limit
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         cfg_r.int_limit <= `TSL_RST_INT_CRIT_LIMIT;
      end else if (req.wr && req.addr == `TSL_OFS_INT_CRIT_LIMIT) begin
         cfg_r.int_limit <= req.wdata;
      end
   end

   // shared hysteresis
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         cfg_r.hyst <= `TSL_RST_CRIT_HYST;
      end else if (req.wr && req.addr == `TSL_OFS_CRIT_HYST) begin
         cfg_r.hyst <= req.wdata;
      end
   end

   // shutdown link bits
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         cfg_r.link <= `TSL_RST_LINK;
      end else if (req.wr && req.addr == `TSL_OFS_SW_SHDN_CONFIG) begin
         cfg_r.link[`TSL_BIT_EXT_LINK] <= req.wdata[`TSL_BIT_EXT_LINK];
         cfg_r.link[`TSL_BIT_INT_LINK] <= req.wdata[`TSL_BIT_INT_LINK];
      end
   end

   // fault flag: a new fault wins over the clearing read
   assign fault_rd = req.rd && req.addr == `TSL_OFS_EXT_FAULT_STATUS;

   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ext_diode_fault_flag_r <= 1'b0;
      end else if (CONV_DONE_IN && EXT_DIODE_FAULT_IN) begin
         ext_diode_fault_flag_r <= 1'b1;
      end else if (fault_rd) begin
         ext_diode_fault_flag_r <= 1'b0;
      end
   end

   // strap capture once after reset release
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         strap_done_r <= 1'b0;
         hw_step_r <= `TSL_RST_HW_STEP;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         hw_step_r <= HW_LIMIT_STRAP_IN;
      end
   end

   assign hw_step_sat = (hw_step_r > `TSL_HW_STEP_MAX) ? `TSL_HW_STEP_MAX : hw_step_r;

   // hardware limit in degrees, in the active range format
   always_comb begin
      hw_limit_value = `TSL_HW_LIMIT_BASE + {2'h0, hw_step_sat};
      if (RANGE_EXT_IN) begin
         hw_limit_value = hw_limit_value + `TSL_EXT_RANGE_OFFSET;
      end
   end

   // register read mux; unmapped offsets read zero
   always_comb begin
      read_mux = 8'h00;
      case (req.addr)
         `TSL_OFS_EXT_CRIT_LIMIT: begin
            read_mux = cfg_r.ext_limit;
         end
         `TSL_OFS_INT_CRIT_LIMIT: begin
            read_mux = cfg_r.int_limit;
         end
         `TSL_OFS_CRIT_HYST: begin
            read_mux = cfg_r.hyst;
         end
         `TSL_OFS_EXT_FAULT_STATUS: begin
            read_mux[`TSL_BIT_EXT_FAULT] = ext_diode_fault_flag_r;
         end
         `TSL_OFS_SW_SHDN_CONFIG: begin
            read_mux[`TSL_BIT_EXT_LINK] = cfg_r.link[`TSL_BIT_EXT_LINK];
            read_mux[`TSL_BIT_INT_LINK] = cfg_r.link[`TSL_BIT_INT_LINK];
         end
         `TSL_OFS_HW_SHDN_LIMIT: begin
            read_mux = hw_limit_value;
         end
         default: begin
            read_mux = 8'h00;
         end
      endcase
   end

   // read data and valid one cycle after the request
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         REG_RDATA_OUT <= 8'h00;
         REG_RVALID_OUT <= 1'b0;
      end else begin
         REG_RVALID_OUT <= req.rd;
         if (req.rd) begin
            REG_RDATA_OUT <= read_mux;
         end
      end
   end

   // consecutive conversion count decode; unlisted codes act as four
   always_comb begin
      case (CONSEC_CRIT_CODE_IN)
         `TSL_CONSEC_1: begin
            consecutive_critical_count = `TSL_COUNT_1;
         end
         `TSL_CONSEC_2: begin
            consecutive_critical_count = `TSL_COUNT_2;
         end
         `TSL_CONSEC_3: begin
            consecutive_critical_count = `TSL_COUNT_3;
         end
         `TSL_CONSEC_4: begin
            consecutive_critical_count = `TSL_COUNT_4;
         end
         default: begin
            consecutive_critical_count = `TSL_COUNT_4;
         end
      endcase
   end

   // compare domain: readings and limits share the active format
   assign ext_temp_u = to_cmp(EXT_TEMP_IN, RANGE_EXT_IN);
   assign int_temp_u = to_cmp(INT_TEMP_IN, RANGE_EXT_IN);
   assign ext_limit_u = to_cmp(cfg_r.ext_limit, RANGE_EXT_IN);
   assign int_limit_u = to_cmp(cfg_r.int_limit, RANGE_EXT_IN);
   assign hw_limit_u = to_cmp(hw_limit_value, RANGE_EXT_IN);
   assign ext_release_u = sub_floor(ext_limit_u, cfg_r.hyst);
   assign int_release_u = sub_floor(int_limit_u, cfg_r.hyst);
   assign hw_release_u = sub_floor(hw_limit_u, `TSL_HW_RELEASE_MARGIN);

   tsl_crit_chan #(
      .W(8)
   ) u_ext_chan (
      .clk_in(CLK_IN),
      .rst_n_in(rst_sync_r),
      .conv_in(CONV_DONE_IN),
      .temp_in(ext_temp_u),
      .limit_in(ext_limit_u),
      .release_in(ext_release_u),
      .need_in(consecutive_critical_count),
      .over_out(ext_over),
      .trip_out(ext_trip)
   );

   tsl_crit_chan #(
      .W(8)
   ) u_int_chan (
      .clk_in(CLK_IN),
      .rst_n_in(rst_sync_r),
      .conv_in(CONV_DONE_IN),
      .temp_in(int_temp_u),
      .limit_in(int_limit_u),
      .release_in(int_release_u),
      .need_in(consecutive_critical_count),
      .over_out(int_over),
      .trip_out(int_trip)
   );

   tsl_crit_chan #(
      .W(8)
   ) u_hw_chan (
      .clk_in(CLK_IN),
      .rst_n_in(rst_sync_r),
      .conv_in(CONV_DONE_IN),
      .temp_in(ext_temp_u),
      .limit_in(hw_limit_u),
      .release_in(hw_release_u),
      .need_in(consecutive_critical_count),
      .over_out(hw_over),
      .trip_out(hw_trip)
   );

   // status follows the limit regardless of the link
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         EXT_CRITICAL_STATUS_OUT <= 1'b0;
         INT_CRITICAL_STATUS_OUT <= 1'b0;
         EXT_DIODE_FAULT_FLAG_OUT <= 1'b0;
      end else begin
         EXT_CRITICAL_STATUS_OUT <= ext_over;
         INT_CRITICAL_STATUS_OUT <= int_over;
         EXT_DIODE_FAULT_FLAG_OUT <= ext_diode_fault_flag_r;
      end
   end

   // pin sources: linked software trips or the hardware trip, no alert mask
   assign shutdown_nxt = (cfg_r.link[`TSL_BIT_EXT_LINK] && ext_trip)
                       || (cfg_r.link[`TSL_BIT_INT_LINK] && int_trip)
                       || hw_trip;

   // open-drain pin driven low while asserted
   always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         SYSTEM_SHUTDOWN_N_OUT <= 1'b1;
         SYSTEM_SHUTDOWN_OE_OUT <= 1'b0;
      end else begin
         SYSTEM_SHUTDOWN_N_OUT <= !shutdown_nxt;
         SYSTEM_SHUTDOWN_OE_OUT <= shutdown_nxt;
      end
   end

endmodule

// ### verif/tsl_top_monitor.sv
/* checker for the thermal shutdown limit block.
   assumes it is bound to tsl_top and sees only its ports. */
`timescale 1ns/1ps
`include "tsl_defs.svh"
module tsl_top_monitor
   import tsl_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   input wire logic REG_RVALID_OUT,
   input wire logic CONV_DONE_IN,
   input wire logic [7:0] EXT_TEMP_IN,
   input wire logic [7:0] INT_TEMP_IN,
   input wire logic EXT_DIODE_FAULT_IN,
   input wire logic RANGE_EXT_IN,
   input wire logic [2:0] CONSEC_CRIT_CODE_IN,
   input wire logic SYSTEM_SHUTDOWN_N_OUT,
   input wire logic SYSTEM_SHUTDOWN_OE_OUT,
   input wire logic EXT_CRITICAL_STATUS_OUT,
   input wire logic INT_CRITICAL_STATUS_OUT,
   input wire logic EXT_DIODE_FAULT_FLAG_OUT
);
   logic [7:0] ext_lim_r;
   logic [7:0] int_lim_r;
   logic [1:0] link_r;
   logic [1:0] run_r;
   logic ext_over;
   logic int_over;

   function automatic logic above(input logic [7:0] t, input logic [7:0] l, input logic r);
      return r ? (t > l) : ($signed(t) > $signed(l));
   endfunction

   assign ext_over = above(EXT_TEMP_IN, ext_lim_r, RANGE_EXT_IN);
   assign int_over = above(INT_TEMP_IN, int_lim_r, RANGE_EXT_IN);

   // shadow of the writable limits and links
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ext_lim_r <= `TSL_RST_EXT_CRIT_LIMIT;
         int_lim_r <= `TSL_RST_INT_CRIT_LIMIT;
         link_r <= `TSL_RST_LINK;
      end else if (REG_WR_IN) begin
         if (REG_ADDR_IN == 8'h19) ext_lim_r <= REG_WDATA_IN;
         if (REG_ADDR_IN == 8'h20) int_lim_r <= REG_WDATA_IN;
         if (REG_ADDR_IN == 8'h1D) link_r <= REG_WDATA_IN[1:0];
      end
   end

   // edges since reset release, saturating
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) run_r <= 2'h0;
      else if (run_r != 2'h3) run_r <= run_r + 2'h1;
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_ext_trip;
      CONV_DONE_IN && CONSEC_CRIT_CODE_IN == 3'h0 && ext_over && link_r[1];
   endsequence
   sequence s_fault_read;
      REG_RD_IN && REG_ADDR_IN == 8'h1B && !(CONV_DONE_IN && EXT_DIODE_FAULT_IN);
   endsequence

   read_valid_a: assert property (run_r == 2'h3
      |-> REG_RVALID_OUT == $past(REG_RD_IN)) else $error("read valid misplaced");
   rdata_hold_a: assert property (run_r == 2'h3 && !$past(REG_RD_IN)
      |-> $stable(REG_RDATA_OUT)) else $error("read data changed without read");
   fault_clear_a: assert property (s_fault_read
      |-> ##2 !EXT_DIODE_FAULT_FLAG_OUT) else $error("fault flag not cleared");
   fault_set_a: assert property (CONV_DONE_IN && EXT_DIODE_FAULT_IN
      |-> ##2 EXT_DIODE_FAULT_FLAG_OUT) else $error("fault flag not set");
   fault_bits_a: assert property (REG_RVALID_OUT && $past(REG_ADDR_IN) == 8'h1B
      |-> (REG_RDATA_OUT & 8'hFD) == 8'h00) else $error("fault status spare bits set");
   ext_status_a: assert property (CONV_DONE_IN
      |-> ##2 EXT_CRITICAL_STATUS_OUT == $past(ext_over, 2)) else $error("ext status wrong");
   int_status_a: assert property (CONV_DONE_IN
      |-> ##2 INT_CRITICAL_STATUS_OUT == $past(int_over, 2)) else $error("int status wrong");
   ext_trip_a: assert property (s_ext_trip
      |-> ##2 !SYSTEM_SHUTDOWN_N_OUT) else $error("linked trip did not assert pin");
   pin_cause_a: assert property (run_r == 2'h3 && $changed(SYSTEM_SHUTDOWN_N_OUT)
      |-> $past(CONV_DONE_IN, 2) || $past(REG_WR_IN) || $past(REG_WR_IN, 2))
      else $error("pin changed without cause");
   pin_enable_a: assert property (SYSTEM_SHUTDOWN_OE_OUT == !SYSTEM_SHUTDOWN_N_OUT)
      else $error("pin enable disagrees with pin level");
endmodule

bind tsl_top tsl_top_monitor tsl_top_monitor_i (.CLK_IN, .RSTN_IN, .REG_ADDR_IN, .REG_WR_IN,
   .REG_RD_IN, .REG_WDATA_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .CONV_DONE_IN, .EXT_TEMP_IN,
   .INT_TEMP_IN, .EXT_DIODE_FAULT_IN, .RANGE_EXT_IN, .CONSEC_CRIT_CODE_IN,
   .SYSTEM_SHUTDOWN_N_OUT, .SYSTEM_SHUTDOWN_OE_OUT, .EXT_CRITICAL_STATUS_OUT,
   .INT_CRITICAL_STATUS_OUT, .EXT_DIODE_FAULT_FLAG_OUT);

// ### verif/tsl_host_model.sv
/* register port host for the thermal shutdown limit block.
   assumes requests change at the falling clock edge. */
`timescale 1ns/1ps
module tsl_host_model
   import tsl_pkg::*;
(
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in,
   output tsl_reg_req_t req_out
);
   initial req_out = '0;

   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk_in);
      req_out.wr = 1'b0;
      req_out.wdata = ~d;
   endtask

   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      @(negedge clk_in);
      req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk_in);
      req_out.rd = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rvalid_in === 1'b1) begin
            ok = 1'b1;
            d = rdata_in;
         end else @(negedge clk_in);
      end
   endtask
endmodule

// ### verif/test_thermal_shutdown_limit_regs.sv
/* testbench for the thermal shutdown limit block.
   assumes tsl_top with the host model and the bound checker. */
`timescale 1ns/1ps
`include "tsl_defs.svh"
module test_thermal_shutdown_limit_regs
   import tsl_pkg::*;
;
   logic clk;
   logic rst_n, conv, fault, range_ext, rvalid, shdn_n, oe, ext_st, int_st, flag, ok;
   logic [7:0] ext_t, int_t, rdata, d;
   logic [2:0] code;
   logic [5:0] strap;
   tsl_reg_req_t req;
   int failures = 0;
   int checks = 0;
   logic [7:0] ofs [3] = '{8'h19, 8'h20, 8'h21};
   logic [7:0] dat [3] = '{8'hA5, 8'h5A, 8'h81};
   logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

   tsl_host_model tsl_host_model_i (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
      .req_out(req));
   tsl_top tsl_top_i (.CLK_IN(clk), .RSTN_IN(rst_n), .REG_ADDR_IN(req.addr),
      .REG_WR_IN(req.wr), .REG_RD_IN(req.rd), .REG_WDATA_IN(req.wdata),
      .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .CONV_DONE_IN(conv),
      .EXT_TEMP_IN(ext_t), .INT_TEMP_IN(int_t), .EXT_DIODE_FAULT_IN(fault),
      .RANGE_EXT_IN(range_ext), .CONSEC_CRIT_CODE_IN(code), .HW_LIMIT_STRAP_IN(strap),
      .SYSTEM_SHUTDOWN_N_OUT(shdn_n), .SYSTEM_SHUTDOWN_OE_OUT(oe),
      .EXT_CRITICAL_STATUS_OUT(ext_st), .INT_CRITICAL_STATUS_OUT(int_st),
      .EXT_DIODE_FAULT_FLAG_OUT(flag));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      tsl_host_model_i.write(a, v);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      tsl_host_model_i.read(a, d, ok);
      if (ok !== 1'b1) begin
         failures++;
         final_report;
      end else begin
         check(d, e);
      end
   endtask

   // one conversion on one channel, then wait for status and pin
   task automatic cv(input logic c, input logic [7:0] t, input logic f);
      @(negedge clk);
      ext_t = c ? t : 8'h00;
      int_t = c ? 8'h00 : t;
      fault = f;
      conv = 1'b1;
      @(negedge clk);
      conv = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // pin level and its enable, which is high only while driving low
   task automatic pin(input logic e);
      check({6'h00, oe, shdn_n}, {6'h00, !e, e});
   endtask

   task automatic st(input logic e, input logic i);
      check({6'h00, ext_st, int_st}, {6'h00, e, i});
   endtask

   initial begin
      rst_n = 1'b0;
      {conv, fault, range_ext, code, ext_t, int_t} = '0;
      strap = 6'h05;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      pin(1'b1);
      rd(8'h19, `TSL_RST_EXT_CRIT_LIMIT);
      rd(8'h20, `TSL_RST_INT_CRIT_LIMIT);
      rd(8'h21, `TSL_RST_CRIT_HYST);
      rd(8'h50, 8'h00);
      rd(8'h1E, 8'h52);
      range_ext = 1'b1;
      rd(8'h1E, 8'h92);
      range_ext = 1'b0;
      for (int k = 0; k < 3; k++) wr(ofs[k], dat[k]);
      for (int k = 0; k < 3; k++) rd(ofs[k], dat[k]);
      wr(8'h1D, 8'hFF);
      rd(8'h1D, 8'h03);
      wr(8'h1E, 8'h00);
      rd(8'h1E, 8'h52);
      wr(8'h1B, 8'hFF);
      rd(8'h1B, 8'h00);
      cv(1'b1, 8'h00, 1'b1);
      check({7'h00, flag}, 8'h01);
      rd(8'h1B, 8'h02);
      rd(8'h1B, 8'h00);
      wr(8'h19, 8'h50);
      wr(8'h20, 8'h40);
      wr(8'h21, 8'h05);
      for (int c = 0; c < 2; c++) begin
         d = c ? 8'h50 : 8'h40;
         wr(8'h1D, 8'h00);
         cv(c[0], d + 8'h01, 1'b0);
         st(c[0], !c[0]);
         pin(1'b1);
         cv(c[0], 8'hF0, 1'b0);
         st(1'b0, 1'b0);
         wr(8'h1D, c ? 8'h02 : 8'h01);
         cv(c[0], d + 8'h01, 1'b0);
         pin(1'b0);
         cv(c[0], d - 8'h04, 1'b0);
         st(1'b0, 1'b0);
         pin(1'b0);
         cv(c[0], d - 8'h06, 1'b0);
         pin(1'b1);
      end
      wr(8'h1D, 8'h02);
      for (int k = 0; k < 4; k++) begin
         code = codes[k];
         repeat (k) cv(1'b1, 8'h51, 1'b0);
         pin(1'b1);
         cv(1'b1, 8'h51, 1'b0);
         pin(1'b0);
         cv(1'b1, 8'h40, 1'b0);
         pin(1'b1);
      end
      code = 3'h0;
      wr(8'h1D, 8'h00);
      wr(8'h19, 8'h7F);
      cv(1'b1, 8'h53, 1'b0);
      pin(1'b0);
      cv(1'b1, 8'h48, 1'b0);
      pin(1'b0);
      cv(1'b1, 8'h47, 1'b0);
      pin(1'b1);
      range_ext = 1'b1;
      cv(1'b1, 8'h93, 1'b0);
      st(1'b1, 1'b0);
      pin(1'b0);
      cv(1'b1, 8'h87, 1'b0);
      pin(1'b1);
      range_ext = 1'b0;
      final_report;
   end
endmodule
